// File: pkg/seep_params.svh
`ifndef SEEP_PARAMS_SVH
`define SEEP_PARAMS_SVH
// Function
// - Start bit is the first serial clock rise with select and serial input high.
// - Before a start bit, pin activity causes no operation at all.
// - An instruction executes only after all its opcode, address and data bits arrive.
// - Two-bit opcode: 10 read, 01 write, 11 erase, 00 special group.
// - Word mode: 10-bit address; read/write/write-all 29 clocks, others 13.
// - Width select high picks 16-bit words, low picks bytes.
// - Input bits are sampled on each rising serial clock edge.
// - Serial output is released except for read data or status; released when select falls.
// - Output low while a self-timed cycle runs, high once ready.
// - Status shows only when select rises after at least 250 ns low following launch.
// - Power-up state is locked; erase and write rejected until unlocked.
// - A word erase sets every bit of the addressed byte to one; in 16-bit mode only the even byte of the word.
// - Low-voltage parts launch on select fall; 5 V part on last-bit clock rise.
// - Erase-all sets the whole array to one, launched like a word erase.
// - After completion, a start bit then select low clears the ready indication.
// - Write-permit input low blocks array writes.
// - A read outputs a single zero bit before the first data bit.
// - Select held high after a read streams successive words.
// - Select low holds the instruction logic in reset.
// - Unlock lasts until lock; reads work in either lock state.
`define SEEP_ABITS_X8        11
`define SEEP_ABITS_X16       10
`define SEEP_DEPTH           2048
`define SEEP_CLKS_X8_DATA    22
`define SEEP_CLKS_X8_CTRL    14
`define SEEP_CLKS_X16_DATA   29
`define SEEP_CLKS_X16_CTRL   13
`define SEEP_SYS_PERIOD_NS   40
`define SEEP_CSL_MIN_NS      250
`define SEEP_CSL_CYC         ((`SEEP_CSL_MIN_NS + `SEEP_SYS_PERIOD_NS - 1) / `SEEP_SYS_PERIOD_NS)
`define SEEP_PROG_CYC        50000
`endif

// File: pkg/seep_pkg.sv
package seep_pkg;
	typedef enum logic [5:0] {
		SEEP_IDLE  = 6'h01,
		SEEP_RECV  = 6'h02,
		SEEP_READ  = 6'h04,
		SEEP_ARMED = 6'h08,
		SEEP_DONE  = 6'h10,
		SEEP_SKIP  = 6'h20
	} seep_state_e;
	typedef enum logic [1:0] {
		SEEP_OP_SPEC  = 2'h0,
		SEEP_OP_WRITE = 2'h1,
		SEEP_OP_READ  = 2'h2,
		SEEP_OP_ERASE = 2'h3
	} seep_op_e;
	typedef enum logic [2:0] {
		SEEP_PG_NONE  = 3'h0,
		SEEP_PG_WRITE = 3'h1,
		SEEP_PG_ERASE = 3'h2,
		SEEP_PG_ERASE_ALL_CMD  = 3'h3,
		SEEP_PG_WRITE_ALL_CMD  = 3'h4
	} seep_pg_e;
endpackage

// File: core/seep_sync.sv
module seep_sync
(
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	// Pin in, synchronised out
	input  wire logic i_pin,
	output logic      o_lvl
);
	typedef struct packed {
		logic s1;
		logic s2;
	} seep_sync_s;
	seep_sync_s st_r;
	seep_sync_s st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = i_pin;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign o_lvl = st_r.s2;
endmodule

// File: core/seep_array.sv
`include "seep_params.svh"
module seep_array
(
	// Clock
	input  wire logic        i_clk_sys,
	// Access
	input  wire logic [10:0] i_addr,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_we,
	input  wire logic [10:0] i_waddr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_fill,
	input  wire logic [7:0]  i_fill_data
);
	// Byte storage; a 16-bit word uses only its even byte, the odd byte is written only by a fill
	logic [7:0] mem_r [0:`SEEP_DEPTH-1];
	always_ff @(posedge i_clk_sys)
	begin
		for (int k = 0; k < `SEEP_DEPTH; k++)
		begin
			if (i_fill)
				mem_r[k] <= i_fill_data;
			else if (i_we && (i_waddr == 11'(k)))
				mem_r[k] <= i_wdata;
		end
	end
	assign o_rdata = mem_r[i_addr];
endmodule

// File: core/seep_port.sv
`include "seep_params.svh"
module seep_port
#(
	parameter int unsigned PROG_CYC    = `SEEP_PROG_CYC,
	parameter bit          HALF_DENS   = 1'b0,
	parameter bit          LAUNCH_CLK  = 1'b0,
	parameter bit          HAS_PERMIT  = 1'b1
)
(
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	// Serial pins
	input  wire logic i_cs,
	input  wire logic i_sclk,
	input  wire logic i_serial_in,
	output logic      o_serial_out,
	output logic      o_serial_out_oe,
	// Configuration pins
	input  wire logic i_word_width_select,
	input  wire logic i_write_permit,
	// Status
	output logic      o_unlocked,
	output logic      o_busy
);
	import seep_pkg::*;

	logic cs_s;
	logic ck_s;
	logic di_s;
	logic org_s;
	logic pe_s;
	seep_sync u_cs  (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin(i_cs),                .o_lvl(cs_s));
	seep_sync u_ck  (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin(i_sclk),              .o_lvl(ck_s));
	seep_sync u_di  (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin(i_serial_in),         .o_lvl(di_s));
	seep_sync u_org (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin(i_word_width_select), .o_lvl(org_s));
	seep_sync u_pe  (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pin(i_write_permit),      .o_lvl(pe_s));

	typedef struct packed {
		seep_state_e st;
		logic        ck_d;
		logic        cs_d;
		logic [4:0]  cnt;
		logic [28:0] sh;
		logic        x16;
		seep_pg_e    pg;
		logic [10:0] addr;
		logic [15:0] wdata;
		logic [15:0] rsh;
		logic [4:0]  rcnt;
		logic        unl;
		logic        busy;
		logic [16:0] pcnt;
		logic [3:0]  csl;
		logic        stat;
		logic        sout;
		logic        soe;
	} seep_port_s;
	seep_port_s r_r;
	seep_port_s r_nxt;

	logic [7:0]  rd_byte;
	logic        we;
	logic [10:0] waddr;
	logic [7:0]  wbyte;
	logic        fill;
	logic [7:0]  fill_byte;
	logic [10:0] rd_addr;

	seep_array u_mem (
		.i_clk_sys  (i_clk_sys),
		.i_addr     (rd_addr),
		.o_rdata    (rd_byte),
		.i_we       (we),
		.i_waddr    (waddr),
		.i_wdata    (wbyte),
		.i_fill     (fill),
		.i_fill_data(fill_byte)
	);

	logic        ck_rise;
	logic        cs_fall;
	logic        cs_rise;
	logic [4:0]  need;
	logic [1:0]  op;
	logic [10:0] fa;
	logic [1:0]  sp;
	logic [15:0] fdat;
	logic        launch;
	logic        lng;
	seep_pg_e    pg_k;

	always_comb
	begin
		ck_rise = ck_s && !r_r.ck_d;
		cs_fall = r_r.cs_d && !cs_s;
		cs_rise = cs_s && !r_r.cs_d;
		r_nxt = r_r;
		r_nxt.ck_d = ck_s;
		r_nxt.cs_d = cs_s;
		we = 1'b0;
		waddr = r_r.addr;
		wbyte = 8'hff;
		fill = 1'b0;
		fill_byte = 8'hff;
		launch = 1'b0;
		pg_k = SEEP_PG_NONE;
		// Received field after the start bit, bit 0 is newest
		// At the control length the fields sit low; data pushes them up
		lng = r_r.x16 ? (r_r.cnt == 5'(`SEEP_CLKS_X16_DATA)) : (r_r.cnt == 5'(`SEEP_CLKS_X8_DATA));
		if (r_r.x16)
		begin
			op = lng ? r_r.sh[27:26] : r_r.sh[11:10];
			fa = lng ? {1'b0, r_r.sh[25:16]} : {1'b0, r_r.sh[9:0]};
			fdat = r_r.sh[15:0];
			sp = fa[9:8];
		end
		else
		begin
			op = lng ? r_r.sh[20:19] : r_r.sh[12:11];
			fa = lng ? r_r.sh[18:8] : r_r.sh[10:0];
			fdat = {8'h00, r_r.sh[7:0]};
			sp = fa[10:9];
		end
		// Read executes at the address end so its data can follow on the same select
		// Past the control length only write and write-all remain, so the shifted opcode is not trusted
		if (r_r.x16)
			need = (r_r.cnt > 5'(`SEEP_CLKS_X16_CTRL) || op == 2'(SEEP_OP_WRITE)
				|| (op == 2'(SEEP_OP_SPEC) && sp == 2'h1))
				? 5'(`SEEP_CLKS_X16_DATA) : 5'(`SEEP_CLKS_X16_CTRL);
		else
			need = (r_r.cnt > 5'(`SEEP_CLKS_X8_CTRL) || op == 2'(SEEP_OP_WRITE)
				|| (op == 2'(SEEP_OP_SPEC) && sp == 2'h1))
				? 5'(`SEEP_CLKS_X8_DATA) : 5'(`SEEP_CLKS_X8_CTRL);
		rd_addr = r_r.x16 ? {r_r.addr[9:0], 1'b0} : r_r.addr;

		// Self-timed cycle runs regardless of select
		if (r_r.busy)
		begin
			r_nxt.pcnt = r_r.pcnt + 17'h00001;
			if (r_r.pg == SEEP_PG_ERASE_ALL_CMD || r_r.pg == SEEP_PG_WRITE_ALL_CMD)
			begin
				// Write-all is an erase-all then one fill with the data byte,
				// so a short cycle count still covers the whole array
				fill = r_r.pcnt == 17'h00000 || (r_r.pg == SEEP_PG_WRITE_ALL_CMD && r_r.pcnt == 17'h00001);
				fill_byte = (r_r.pcnt == 17'h00000) ? 8'hff : r_r.wdata[7:0];
			end
			if (r_r.pcnt == 17'(PROG_CYC - 1))
				r_nxt.busy = 1'b0;
		end

		if (!cs_s)
		begin
			r_nxt.st = SEEP_IDLE;
			r_nxt.soe = 1'b0;
			r_nxt.csl = (r_r.csl == 4'hf) ? r_r.csl : r_r.csl + 4'h1;
			if (cs_fall && r_r.st == SEEP_ARMED && !LAUNCH_CLK)
				launch = 1'b1;
			if (cs_fall && r_r.st == SEEP_DONE)
				r_nxt.stat = 1'b0;
		end
		else
		begin
			if (cs_rise)
			begin
				// Status shown only after a real deselect gap
				if (r_r.stat && r_r.csl >= 4'(`SEEP_CSL_CYC))
				begin
					r_nxt.soe = 1'b1;
					r_nxt.sout = !r_r.busy;
				end
				r_nxt.csl = 4'h0;
			end
			if (r_r.soe && r_r.st == SEEP_IDLE && r_r.stat)
				r_nxt.sout = !r_r.busy;
			if (ck_rise)
			begin
				case (r_r.st)
					SEEP_IDLE:
					begin
						if (di_s)
						begin
							r_nxt.st = SEEP_RECV;
							r_nxt.cnt = 5'h01;
							r_nxt.sh = '0;
							r_nxt.x16 = org_s;
							if (r_r.soe && r_r.stat && !r_r.busy)
								r_nxt.st = SEEP_DONE;
						end
					end
					SEEP_DONE:
						r_nxt.st = SEEP_DONE;
					SEEP_RECV:
					begin
						r_nxt.sh = {r_r.sh[27:0], di_s};
						r_nxt.cnt = r_r.cnt + 5'h01;
					end
					SEEP_READ:
					begin
						r_nxt.sout = r_r.rsh[15];
						r_nxt.rsh = {r_r.rsh[14:0], 1'b0};
						r_nxt.rcnt = r_r.rcnt - 5'h01;
						if (r_r.rcnt == 5'h01)
						begin
							r_nxt.addr = r_r.addr + 11'h001;
							r_nxt.rcnt = r_r.x16 ? 5'h10 : 5'h08;
							r_nxt.rsh = r_r.x16 ? {rd_byte, 8'h00} : {rd_byte, 8'h00};
						end
					end
					default:
						r_nxt.st = r_r.st;
				endcase
			end
			// Complete instruction: decode only once all bits are in
			if (r_r.st == SEEP_RECV && r_r.cnt == need)
			begin
				r_nxt.st = SEEP_SKIP;
				r_nxt.addr = fa;
				if (HALF_DENS)
					r_nxt.addr[r_r.x16 ? 9 : 10] = 1'b0;
				if (r_r.x16)
					r_nxt.addr[10] = 1'b0;
				r_nxt.wdata = fdat;
				case (op)
					2'(SEEP_OP_READ):
					begin
						r_nxt.st = SEEP_READ;
						r_nxt.soe = 1'b1;
						r_nxt.sout = 1'b0;
						r_nxt.stat = 1'b0;
						r_nxt.rcnt = r_r.x16 ? 5'h10 : 5'h08;
					end
					2'(SEEP_OP_WRITE):
						pg_k = SEEP_PG_WRITE;
					2'(SEEP_OP_ERASE):
						pg_k = SEEP_PG_ERASE;
					default:
					begin
						case (sp)
							2'h3: r_nxt.unl = 1'b1;
							2'h0: r_nxt.unl = 1'b0;
							2'h2: pg_k = SEEP_PG_ERASE_ALL_CMD;
							default: pg_k = SEEP_PG_WRITE_ALL_CMD;
						endcase
					end
				endcase
				// Locked or write-blocked programming is swallowed
				if (pg_k != SEEP_PG_NONE && r_r.unl && !r_r.busy
					&& !(HAS_PERMIT && !pe_s))
				begin
					r_nxt.pg = pg_k;
					r_nxt.st = SEEP_ARMED;
					if (LAUNCH_CLK)
						launch = 1'b1;
				end
			end
			// Prime the read shifter once the address is latched or has advanced;
			// the last data bit may be high, so the output level is no qualifier
			if (r_r.st == SEEP_READ && r_r.rcnt == (r_r.x16 ? 5'h10 : 5'h08) && !ck_rise)
				r_nxt.rsh = r_r.x16 ? {rd_byte, 8'h00} : {rd_byte, 8'h00};
		end

		if (launch)
		begin
			r_nxt.busy = 1'b1;
			r_nxt.pcnt = '0;
			r_nxt.stat = 1'b1;
			if (LAUNCH_CLK)
				r_nxt.st = SEEP_ARMED;
			if (r_nxt.pg == SEEP_PG_WRITE)
			begin
				we = 1'b1;
				waddr = rd_addr;
				wbyte = r_nxt.wdata[7:0];
			end
			if (r_nxt.pg == SEEP_PG_ERASE)
			begin
				we = 1'b1;
				waddr = rd_addr;
				wbyte = 8'hff;
			end
			if (r_nxt.pg == SEEP_PG_ERASE_ALL_CMD)
				fill = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			r_r <= '0;
			r_r.st <= SEEP_IDLE;
			r_r.pg <= SEEP_PG_NONE;
			r_r.unl <= 1'b0;
		end
		else
			r_r <= r_nxt;
	end

	assign o_serial_out = r_r.sout;
	assign o_serial_out_oe = r_r.soe;
	assign o_unlocked = r_r.unl;
	assign o_busy = r_r.busy;
endmodule

// File: verification/seep_checker.sv
module seep_checker
#(
	parameter int unsigned PROG_CYC = 20
)
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Serial pins
	input wire logic i_cs,
	input wire logic i_sclk,
	input wire logic i_serial_in,
	input wire logic o_serial_out,
	input wire logic o_serial_out_oe,
	// Configuration and status
	input wire logic i_word_width_select,
	input wire logic i_write_permit,
	input wire logic o_unlocked,
	input wire logic o_busy
);
	localparam int BMAX = PROG_CYC + 8;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_locked_at_reset: assert property ($rose(i_rst_b) |-> !o_unlocked && !o_busy && !o_serial_out_oe)
		else $error("not locked and idle after reset");
	a_busy_needs_unlock: assert property ($rose(o_busy) |-> o_unlocked)
		else $error("program cycle while locked");
	a_busy_permit: assert property ($rose(o_busy) |-> i_write_permit)
		else $error("program cycle with permit low");
	a_busy_drives_low: assert property (o_busy && o_serial_out_oe |-> !o_serial_out)
		else $error("output high while busy");
	a_busy_min_len: assert property ($rose(o_busy) |-> o_busy [*8])
		else $error("program cycle too short");
	a_busy_ends: assert property ($rose(o_busy) |-> ##[1:BMAX] !o_busy)
		else $error("program cycle never ends");
	a_oe_release: assert property (!i_cs [*6] |-> !o_serial_out_oe)
		else $error("output driven while deselected");
	a_idle_lock_hold: assert property (!i_cs [*8] |=> $stable(o_unlocked))
		else $error("lock state changed while deselected");
	a_oe_needs_cs: assert property ($rose(o_serial_out_oe) |-> i_cs)
		else $error("output enabled without select");
	c_busy: cover property ($rose(o_busy));
	c_unlock: cover property ($rose(o_unlocked));
	c_zero_out: cover property ($rose(o_serial_out_oe) && !o_serial_out);
endmodule
bind seep_port seep_checker #(.PROG_CYC(PROG_CYC)) seep_checker_inst (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cs(i_cs), .i_sclk(i_sclk),
	.i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
	.i_word_width_select(i_word_width_select), .i_write_permit(i_write_permit),
	.o_unlocked(o_unlocked), .o_busy(o_busy));

// File: verification/seep_host.sv
module seep_host
(
	// Clock
	input  wire logic i_clk_sys,
	// Device output
	input  wire logic i_so,
	input  wire logic i_so_oe,
	// Host pins
	output logic      o_cs,
	output logic      o_sclk,
	output logic      o_di
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_cs = 1'b0;
		o_sclk = 1'b0;
		o_di = 1'b0;
	end
	// A released output reads as unknown so it never passes for data
	function automatic logic so();
		return i_so_oe ? i_so : 1'bx;
	endfunction
	task automatic frame(input logic [31:0] b, input int n, output logic [31:0] rd);
		rd = '0;
		o_cs = 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			o_di = b[i];
			repeat (4) @(negedge i_clk_sys);
			rd = {rd[30:0], so()};
			o_sclk = 1'b1;
			repeat (4) @(negedge i_clk_sys);
			o_sclk = 1'b0;
		end
		repeat (4) @(negedge i_clk_sys);
		rd = {rd[30:0], so()};
		o_cs = 1'b0;
		o_di = ~o_di;
		repeat (8) @(negedge i_clk_sys);
	endtask
	task automatic poll(output logic r);
		o_cs = 1'b1;
		repeat (8) @(negedge i_clk_sys);
		r = so();
	endtask
endmodule

// File: verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {bit w; logic [16:0] v; string n;} seep_exp_s;
	logic        clk_sys = 1'b0;
	logic        rst_b, cs, sclk, sdi, so, so_oe, ww, permit, unlocked, busy, r;
	logic [16:0] obs;
	logic [31:0] rd;
	logic [10:0] a;
	logic [7:0]  d, d2;
	int          fail_count = 0;
	int          checked = 0;
	seep_exp_s   q[$];
	seep_exp_s   e;
	event        ev;
	always #20 clk_sys = ~clk_sys;
	seep_port #(.PROG_CYC(200)) seep_port_inst (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_cs(cs),
		.i_sclk(sclk), .i_serial_in(sdi), .o_serial_out(so), .o_serial_out_oe(so_oe),
		.i_word_width_select(ww), .i_write_permit(permit), .o_unlocked(unlocked), .o_busy(busy));
	seep_host seep_host_inst (.i_clk_sys(clk_sys), .i_so(so), .i_so_oe(so_oe), .o_cs(cs), .o_sclk(sclk),
		.o_di(sdi));
	task automatic give_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp_word(input logic [16:0] x, input logic [16:0] g, input string n);
		checked++;
		if (g !== x)
		begin
			$display("Error %s expected %h seen %h", n, x, g);
			fail_count++;
		end
	endtask
	task automatic cmp_bit(input logic x, input logic g, input string n);
		checked++;
		if (g !== x)
		begin
			$display("Error %s expected %b seen %b", n, x, g);
			fail_count++;
		end
	endtask
	always @(ev)
	begin
		e = q.pop_front();
		if (e.w)
			cmp_word(e.v, obs, e.n);
		else
			cmp_bit(e.v[0], obs[0], e.n);
	end
	task automatic chk(input bit w, input logic [16:0] v, input logic [16:0] o, input string n);
		q.push_back('{w, v, n});
		obs = o;
		->ev;
		@(negedge clk_sys);
	endtask
	task automatic op(input logic [31:0] b, input int n);
		seep_host_inst.frame(b, n, rd);
	endtask
	// Poll status, wait for ready, then clear it with a lone start bit
	task automatic rdy();
		seep_host_inst.poll(r);
		chk(0, 17'h0, {16'h0, r}, "status busy");
		for (int k = 0; k < 400 && r !== 1'b1; k++)
		begin
			@(negedge clk_sys);
			r = seep_host_inst.so();
		end
		chk(0, 17'h1, {16'h0, r}, "status ready");
		op(32'h1, 1);
		chk(0, 17'h0, {16'h0, so_oe}, "output enable");
	endtask
	// Two leading idle clocks, then a read streaming two words
	task automatic rdw(input logic [16:0] x);
		op({1'b1, 2'b10, a, 16'h0}, 32);
		chk(1, x, rd[16:0], "read word");
	endtask
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		fail_count++;
		give_verdict();
	end
	initial
	begin
		rst_b = 1'b0;
		ww = 1'b0;
		permit = 1'b1;
		void'($urandom(32'h388ad879));
		a = 11'($urandom % 2047);
		d = 8'($urandom);
		d2 = 8'($urandom);
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(0, 17'h0, {16'h0, unlocked}, "unlocked");
		op({1'b1, 2'b01, a, d}, 22);
		chk(0, 17'h0, {16'h0, busy}, "busy");
		op({1'b1, 2'b00, 2'b11, 9'h0}, 10);
		chk(0, 17'h0, {16'h0, unlocked}, "unlocked");
		op({1'b1, 2'b00, 2'b11, 9'h0}, 14);
		chk(0, 17'h1, {16'h0, unlocked}, "unlocked");
		op({1'b1, 2'b00, 2'b10, 9'h0}, 14);
		rdy();
		rdw({1'b0, 16'hffff});
		op({1'b1, 2'b01, a, d}, 22);
		rdy();
		rdw({1'b0, d, 8'hff});
		op({1'b1, 2'b11, a}, 14);
		rdy();
		rdw({1'b0, 16'hffff});
		op({1'b1, 2'b00, 2'b01, 9'h0, d2}, 22);
		rdy();
		rdw({1'b0, d2, d2});
		permit = 1'b0;
		op({1'b1, 2'b01, a, ~d2}, 22);
		chk(0, 17'h0, {16'h0, busy}, "busy");
		rdw({1'b0, d2, d2});
		permit = 1'b1;
		ww = 1'b1;
		op({1'b1, 2'b00, 2'b00, 8'h0}, 13);
		chk(0, 17'h0, {16'h0, unlocked}, "unlocked");
		op({1'b1, 2'b11, 10'h0}, 13);
		chk(0, 17'h0, {16'h0, busy}, "busy");
		give_verdict();
	end
endmodule
